// ---- rbm_core.v ----
// Purpose: Executes byte accesses, single-bit read-modify-write and block move.
// Assumes: Commands arrive from the instruction decoder one at a time.
// Notes: Holds the port latch, port direction, a reloadable timer and RAM.
`include "rbm_defs.vh"
`default_nettype none

module rbm_core (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Command port
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire [15:0] cmd_addr,
    input wire [2:0] cmd_bit,
    input wire cmd_carry,
    input wire [7:0] cmd_wdata,
    input wire [7:0] move_count_reg,
    input wire [15:0] move_source_reg,
    input wire [15:0] move_dest_reg,
    output reg cmd_ready_q,
    output reg cmd_done_q,
    output reg [7:0] rd_data_q,
    // CPU state control
    input wire exc_req,
    input wire sleep_req,
    input wire standby_sel,
    input wire wake_req,
    output reg [1:0] cpu_state_q,
    output reg halt_standby_q,
    // Port pins
    input wire [7:0] pin_in,
    output reg [7:0] pin_out_q,
    output reg [7:0] pin_oe_q
);
    localparam S_IDLE = 2'h0;
    localparam S_RA = 2'h1;
    localparam S_RD = 2'h2;
    localparam S_WR = 2'h3;
    localparam [15:0] RAM_BASE = `RBM_RAM_BASE;

    reg [1:0] state_q;
    reg [2:0] op_q;
    reg [15:0] addr_q;
    reg [15:0] src_q;
    reg [15:0] dst_q;
    reg [7:0] count_q;
    reg [2:0] bit_q;
    reg carry_q;
    reg [7:0] wdat_q;
    reg [7:0] periph_q;
    reg [7:0] timer_cnt_q;
    reg [7:0] timer_reload_q;
    wire [7:0] ram_rdata;
    wire [7:0] rd_byte;
    wire ram_we;
    wire cpu_leave;

    // ======================================================
    // Decode and data functions

    function in_ram;
        input [15:0] a;
        begin
            in_ram = (a[15:`RBM_RAM_AW] == RAM_BASE[15:`RBM_RAM_AW]);
        end
    endfunction

    // Peripheral read value for one address.
    function [7:0] periph_read;
        input [15:0] a;
        input [7:0] dir;
        input [7:0] latch;
        input [7:0] pins;
        input [7:0] cnt;
        begin
            case (a)
                `RBM_PORT_DATA_ADDR: periph_read = (dir & latch) | (~dir & pins);
                `RBM_PORT_DIR_ADDR: periph_read = `RBM_WO_READ;
                `RBM_TIMER_ADDR: periph_read = cnt;
                default: periph_read = `RBM_UNMAPPED_READ;
            endcase
        end
    endfunction

    // One-bit change applied to the byte that was read.
    function [7:0] bit_modify;
        input [2:0] op;
        input [7:0] d;
        input [2:0] b;
        input c;
        reg [7:0] m;
        begin
            m = 8'h01 << b;
            case (op)
                `RBM_OP_SET: bit_modify = d | m;
                `RBM_OP_CLEAR: bit_modify = d & ~m;
                `RBM_OP_INVERT: bit_modify = d ^ m;
                `RBM_OP_STORE: bit_modify = c ? (d | m) : (d & ~m);
                `RBM_OP_STORE_INV: bit_modify = c ? (d & ~m) : (d | m);
                default: bit_modify = d;
            endcase
        end
    endfunction

    // ======================================================
    // RAM

    assign ram_we = (state_q == S_WR) && in_ram(addr_q);
    assign rd_byte = in_ram(addr_q) ? ram_rdata : periph_q;

    rbm_ram rbm_ram_i (
        .sys_clk(sys_clk),
        .wr_en(ram_we),
        .wr_addr(addr_q[`RBM_RAM_AW-1:0]),
        .wr_data(wdat_q),
        .rd_addr(addr_q[`RBM_RAM_AW-1:0]),
        .rd_data_q(ram_rdata)
    );

    // ======================================================
    // Access sequencer

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            op_q <= `RBM_OP_READ;
            addr_q <= 16'h0000;
            src_q <= 16'h0000;
            dst_q <= 16'h0000;
            count_q <= 8'h00;
            bit_q <= 3'h0;
            carry_q <= 1'b0;
            wdat_q <= 8'h00;
            periph_q <= 8'h00;
            cmd_ready_q <= 1'b0;
            cmd_done_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            cmd_done_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    // Ready drops at the edge that leaves execution, never one cycle late.
                    cmd_ready_q <= (cpu_state_q == `RBM_CPU_EXEC) && !cpu_leave;
                    if (cmd_valid && cmd_ready_q) begin
                        cmd_ready_q <= 1'b0;
                        op_q <= cmd_op;
                        bit_q <= cmd_bit;
                        carry_q <= cmd_carry;
                        wdat_q <= cmd_wdata;
                        if (cmd_op == `RBM_OP_MOVE) begin
                            // Destination wrap past the top is excluded by software.
                            count_q <= move_count_reg;
                            src_q <= move_source_reg;
                            dst_q <= move_dest_reg;
                            addr_q <= move_source_reg;
                            if (move_count_reg == 8'h00) begin
                                cmd_done_q <= 1'b1;
                            end else begin
                                state_q <= S_RA;
                            end
                        end else if (cmd_op == `RBM_OP_WRITE) begin
                            addr_q <= cmd_addr;
                            state_q <= S_WR;
                        end else begin
                            addr_q <= cmd_addr;
                            state_q <= S_RA;
                        end
                    end
                end
                S_RA: begin
                    periph_q <= periph_read(addr_q, pin_oe_q, pin_out_q, pin_in, timer_cnt_q);
                    state_q <= S_RD;
                end
                S_RD: begin
                    if (op_q == `RBM_OP_READ) begin
                        rd_data_q <= rd_byte;
                        cmd_done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (op_q == `RBM_OP_MOVE) begin
                        wdat_q <= rd_byte;
                        addr_q <= dst_q;
                        state_q <= S_WR;
                    end else begin
                        wdat_q <= bit_modify(op_q, rd_byte, bit_q, carry_q);
                        state_q <= S_WR;
                    end
                end
                S_WR: begin
                    if (op_q == `RBM_OP_MOVE && count_q != 8'h01) begin
                        count_q <= count_q - 8'h01;
                        src_q <= src_q + 16'h0001;
                        dst_q <= dst_q + 16'h0001;
                        addr_q <= src_q + 16'h0001;
                        state_q <= S_RA;
                    end else begin
                        count_q <= 8'h00;
                        cmd_done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ======================================================
    // Peripheral registers

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_out_q <= `RBM_PORT_DATA_RST;
            pin_oe_q <= `RBM_PORT_DIR_RST;
            timer_cnt_q <= `RBM_TIMER_RST;
            timer_reload_q <= `RBM_TIMER_RST;
        end else begin
            if (timer_cnt_q == `RBM_TIMER_TOP) begin
                timer_cnt_q <= timer_reload_q;
            end else begin
                timer_cnt_q <= timer_cnt_q + 8'h01;
            end
            if (state_q == S_WR) begin
                case (addr_q)
                    // The whole byte lands in the latch; bits whose direction bit is set drive the pins next cycle.
                    `RBM_PORT_DATA_ADDR: pin_out_q <= wdat_q;
                    `RBM_PORT_DIR_ADDR: pin_oe_q <= wdat_q;
                    `RBM_TIMER_ADDR: timer_reload_q <= wdat_q;
                    default: pin_out_q <= pin_out_q;
                endcase
            end
        end
    end

    // ======================================================
    // CPU state

    // Exception and sleep requests are acted on only while the command port is idle and ready.
    assign cpu_leave = (cpu_state_q == `RBM_CPU_EXEC) && cmd_ready_q && !cmd_valid
        && (exc_req || sleep_req);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cpu_state_q <= `RBM_CPU_RESET;
            halt_standby_q <= 1'b0;
        end else begin
            case (cpu_state_q)
                `RBM_CPU_RESET: cpu_state_q <= `RBM_CPU_EXC;
                `RBM_CPU_EXC: cpu_state_q <= `RBM_CPU_EXEC;
                `RBM_CPU_EXEC: begin
                    if (cpu_leave) begin
                        if (exc_req) begin
                            cpu_state_q <= `RBM_CPU_EXC;
                        end else if (sleep_req) begin
                            cpu_state_q <= `RBM_CPU_HALT;
                            halt_standby_q <= standby_sel;
                        end
                    end
                end
                `RBM_CPU_HALT: begin
                    if (wake_req) begin
                        cpu_state_q <= `RBM_CPU_EXC;
                        halt_standby_q <= 1'b0;
                    end
                end
                default: cpu_state_q <= `RBM_CPU_RESET;
            endcase
        end
    end
endmodule

`default_nettype wire

// ---- rbm_defs.vh ----
// Purpose: Constants for the read-modify-write bit manipulation unit.
// Assumes: 16-bit address space, byte-wide internal bus, one clock.
// Notes: Included by rbm_core.v and rbm_ram.v.
`ifndef RBM_DEFS_VH
`define RBM_DEFS_VH

// ==========================================================
// Address map
`define RBM_RAM_BASE 16'hFB80
`define RBM_RAM_AW 7
`define RBM_PORT_DATA_ADDR 16'hFFD8
`define RBM_PORT_DIR_ADDR 16'hFFE8
`define RBM_TIMER_ADDR 16'hFFB3

// ==========================================================
// Read values, reset values and timer top
`define RBM_WO_READ 8'hFF
`define RBM_UNMAPPED_READ 8'h00
`define RBM_PORT_DATA_RST 8'h00
`define RBM_PORT_DIR_RST 8'h00
`define RBM_TIMER_RST 8'h00
`define RBM_TIMER_TOP 8'hFF

// ==========================================================
// Command codes
`define RBM_OP_READ 3'h0
`define RBM_OP_WRITE 3'h1
`define RBM_OP_SET 3'h2
`define RBM_OP_CLEAR 3'h3
`define RBM_OP_INVERT 3'h4
`define RBM_OP_STORE 3'h5
`define RBM_OP_STORE_INV 3'h6
`define RBM_OP_MOVE 3'h7

// ==========================================================
// CPU states
`define RBM_CPU_RESET 2'h0
`define RBM_CPU_EXEC 2'h1
`define RBM_CPU_HALT 2'h2
`define RBM_CPU_EXC 2'h3

`endif

// ---- rbm_ram.v ----
// Purpose: Small on-chip RAM for the bit manipulation unit.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data come out of a register, one cycle after the address.
`include "rbm_defs.vh"
`default_nettype none

module rbm_ram (
    // Clock
    input wire sys_clk,
    // Write side
    input wire wr_en,
    input wire [`RBM_RAM_AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    // Read side
    input wire [`RBM_RAM_AW-1:0] rd_addr,
    output reg [7:0] rd_data_q
);
    reg [7:0] mem [0:(1<<`RBM_RAM_AW)-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule

`default_nettype wire

// ---- rbm_core_monitor.sv ----
// Purpose: Port assertions for rbm_core.
// Assumes: One clock, synchronous active-high reset.
// Notes: Attached to every rbm_core by the bind below.
`include "rbm_defs.vh"
`default_nettype none
module rbm_mon (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Command port
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0] move_count_reg,
    input wire logic cmd_ready_q,
    input wire logic cmd_done_q,
    input wire logic [7:0] rd_data_q,
    // CPU state and port
    input wire logic exc_req,
    input wire logic sleep_req,
    input wire logic [1:0] cpu_state_q,
    input wire logic [7:0] pin_oe_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire take = cmd_valid && cmd_ready_q;
    reset_clear_a: assert property (disable iff (1'h0) sys_rst |=>
        cpu_state_q == `RBM_CPU_RESET && !cmd_ready_q && pin_oe_q == 8'h00)
        else $error("outputs not cleared in reset");
    reset_exit_a: assert property ($fell(sys_rst) |=>
        cpu_state_q == `RBM_CPU_EXC ##1 cpu_state_q == `RBM_CPU_EXEC)
        else $error("reset exit sequence wrong");
    taken_busy_a: assert property (take |=> !cmd_ready_q)
        else $error("ready stayed high after a command");
    done_pulse_a: assert property (cmd_done_q |=> !cmd_done_q && cmd_ready_q)
        else $error("done not a single pulse before ready");
    bitop_time_a: assert property (take && cmd_op >= `RBM_OP_SET &&
        cmd_op <= `RBM_OP_STORE_INV |-> ##[4:5] cmd_done_q)
        else $error("bit operation latency wrong");
    wo_read_a: assert property (take && cmd_op == `RBM_OP_READ &&
        cmd_addr == `RBM_PORT_DIR_ADDR |-> ##[3:4] cmd_done_q && rd_data_q == `RBM_WO_READ)
        else $error("write-only read not all ones");
    move_zero_a: assert property (take && cmd_op == `RBM_OP_MOVE &&
        move_count_reg == 8'h00 |-> ##[1:2] cmd_done_q)
        else $error("empty move did not end at once");
    halt_idle_a: assert property (cpu_state_q == `RBM_CPU_HALT |-> !cmd_ready_q)
        else $error("commands accepted while halted");
    exc_short_a: assert property (cpu_state_q == `RBM_CPU_EXC |=>
        cpu_state_q == `RBM_CPU_EXEC) else $error("exception state too long");
    sleep_in_a: assert property (sleep_req && !exc_req && cmd_ready_q && !cmd_valid |->
        ##[1:2] cpu_state_q == `RBM_CPU_HALT) else $error("halt not entered");
    exc_in_a: assert property (exc_req && cmd_ready_q && !cmd_valid |=>
        cpu_state_q == `RBM_CPU_EXC) else $error("exception state not entered");
endmodule
bind rbm_core rbm_mon rbm_mon_i (.sys_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr,
    .move_count_reg, .cmd_ready_q, .cmd_done_q, .rd_data_q, .exc_req, .sleep_req, .cpu_state_q,
    .pin_oe_q);
`default_nettype wire

// ---- rbm_pins.sv ----
// Purpose: Board model of the port pins around rbm_core.
// Assumes: Undriven pins follow ext_level set by the bench.
// Notes: Driven pins read back the level the core puts out.
`default_nettype none
module rbm_pins (
    // Core side
    input wire logic [7:0] pin_out_q,
    input wire logic [7:0] pin_oe_q,
    // Outside world
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & ext_level);
endmodule
`default_nettype wire

// ---- rbm_core_tb.sv ----
// Purpose: Self-checking bench for rbm_core.
// Assumes: Command timing as handed over with the design.
// Notes: Pins are modelled by rbm_pins.
`include "rbm_defs.vh"
`default_nettype none
module rbm_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic cmd_valid = 1'h0;
    logic cmd_carry = 1'h0;
    logic [2:0] cmd_op = 3'h0;
    logic [2:0] cmd_bit = 3'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [15:0] move_source_reg = 16'h0000;
    logic [15:0] move_dest_reg = 16'h0000;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] move_count_reg = 8'h00;
    logic [7:0] ext_level = 8'h00;
    logic exc_req = 1'h0;
    logic sleep_req = 1'h0;
    logic standby_sel = 1'h0;
    logic wake_req = 1'h0;
    wire logic cmd_ready_q, cmd_done_q, halt_standby_q;
    wire logic [7:0] rd_data_q, pin_out_q, pin_oe_q, pin_in;
    wire logic [1:0] cpu_state_q;
    int n_errors = 0;
    int n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    rbm_core rbm_core_i (.sys_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_bit,
        .cmd_carry, .cmd_wdata, .move_count_reg, .move_source_reg, .move_dest_reg,
        .cmd_ready_q, .cmd_done_q, .rd_data_q, .exc_req, .sleep_req, .standby_sel,
        .wake_req, .cpu_state_q, .halt_standby_q, .pin_in, .pin_out_q, .pin_oe_q);
    rbm_pins rbm_pins_i (.pin_out_q, .pin_oe_q, .ext_level, .pin_in);
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmd(input logic [2:0] op, input logic [15:0] a, input logic [2:0] b,
            input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_valid <= 1'h1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_bit <= b;
        cmd_wdata <= d;
        cmd_carry <= d[0];
        // The request stands until an edge at which ready is seen high.
        do begin
            @(posedge sys_clk);
            n++;
        end while (cmd_ready_q !== 1'h1 && n < 50);
        cmd_valid <= 1'h0;
        n = 0;
        // An empty move answers at the taking edge itself, so look there first.
        #1;
        while (cmd_done_q !== 1'h1 && n < 50) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 50) check(8'h00, 8'h01);
    endtask
    task rd(input logic [15:0] a, input logic [7:0] exp);
        cmd(`RBM_OP_READ, a, 3'h0, 8'h00);
        check(rd_data_q, exp);
    endtask
    task automatic go_state(input logic [1:0] s);
        int n;
        n = 0;
        while (cpu_state_q !== s && n < 50) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check({6'h00, cpu_state_q}, {6'h00, s});
    endtask
    task t_port;
        cmd(`RBM_OP_WRITE, `RBM_PORT_DIR_ADDR, 3'h0, 8'h3F);
        cmd(`RBM_OP_WRITE, `RBM_PORT_DATA_ADDR, 3'h0, 8'h80);
        @(posedge sys_clk);
        ext_level <= 8'h40;
        cmd(`RBM_OP_SET, `RBM_PORT_DATA_ADDR, 3'h0, 8'h00);
        check(pin_out_q, 8'h41);
        @(posedge sys_clk);
        ext_level <= 8'h80;
        rd(`RBM_PORT_DATA_ADDR, 8'h81);
        cmd(`RBM_OP_CLEAR, `RBM_PORT_DIR_ADDR, 3'h0, 8'h00);
        check(pin_oe_q, 8'hFE);
        rd(`RBM_PORT_DIR_ADDR, `RBM_WO_READ);
        $display("port test done");
    endtask
    task t_ops;
        logic [2:0] ops[5] = '{`RBM_OP_SET, `RBM_OP_CLEAR, `RBM_OP_INVERT, `RBM_OP_STORE,
            `RBM_OP_STORE_INV};
        logic [2:0] bits[5] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h0};
        logic [7:0] exp[5] = '{8'h5B, 8'h59, 8'hD9, 8'hDD, 8'hDC};
        cmd(`RBM_OP_WRITE, 16'hFB85, 3'h0, 8'h5A);
        for (int i = 0; i < 5; i++) begin
            cmd(ops[i], 16'hFB85, bits[i], 8'h01);
            rd(16'hFB85, exp[i]);
        end
        $display("bit operation test done");
    endtask
    task t_misc;
        logic [7:0] r;
        cmd(`RBM_OP_WRITE, 16'h1234, 3'h0, 8'hA5);
        rd(16'h1234, `RBM_UNMAPPED_READ);
        cmd(`RBM_OP_WRITE, `RBM_TIMER_ADDR, 3'h0, 8'hF0);
        // Let the counter wrap at least once so that it reloads from the new value.
        repeat (260) @(posedge sys_clk);
        cmd(`RBM_OP_READ, `RBM_TIMER_ADDR, 3'h0, 8'h00);
        r = rd_data_q;
        cmd(`RBM_OP_READ, `RBM_TIMER_ADDR, 3'h0, 8'h00);
        check({7'h00, rd_data_q === r}, 8'h00);
        check({7'h00, r >= 8'hF0}, 8'h01);
        $display("unmapped and timer test done");
    endtask
    task t_move;
        for (int i = 0; i < 3; i++)
            cmd(`RBM_OP_WRITE, 16'hFB90 + 16'(i), 3'h0, 8'h11 * 8'(i + 1));
        cmd(`RBM_OP_WRITE, 16'hFBB0, 3'h0, 8'h77);
        // Destinations sit far below the top of the space.
        @(posedge sys_clk);
        move_count_reg <= 8'h03;
        move_source_reg <= 16'hFB90;
        move_dest_reg <= 16'hFBA0;
        cmd(`RBM_OP_MOVE, 16'h0000, 3'h0, 8'h00);
        for (int i = 0; i < 3; i++)
            rd(16'hFBA0 + 16'(i), 8'h11 * 8'(i + 1));
        @(posedge sys_clk);
        move_count_reg <= 8'h00;
        move_dest_reg <= 16'hFBB0;
        cmd(`RBM_OP_MOVE, 16'h0000, 3'h0, 8'h00);
        rd(16'hFBB0, 8'h77);
        $display("block move test done");
    endtask
    task t_state;
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk);
            standby_sel <= s[0];
            sleep_req <= 1'h1;
            go_state(`RBM_CPU_HALT);
            check({7'h00, halt_standby_q}, {7'h00, s[0]});
            @(posedge sys_clk);
            sleep_req <= 1'h0;
            wake_req <= 1'h1;
            go_state(`RBM_CPU_EXEC);
            @(posedge sys_clk);
            wake_req <= 1'h0;
        end
        @(posedge sys_clk);
        exc_req <= 1'h1;
        go_state(`RBM_CPU_EXC);
        @(posedge sys_clk);
        exc_req <= 1'h0;
        go_state(`RBM_CPU_EXEC);
        $display("state test done");
    endtask
    initial begin
        #200000;
        n_errors++;
        results;
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'h0;
        go_state(`RBM_CPU_EXEC);
        check(pin_oe_q, `RBM_PORT_DIR_RST);
        t_port;
        t_ops;
        t_misc;
        t_move;
        t_state;
        results;
    end
endmodule
`default_nettype wire
